// ### hw/bas_regs.svh
// Constants for the burst address sequencer
//
// Behaviour
// - Wrapped burst stays in a group of 16, 32, 64 or 128 bytes, self-aligned.
// - Wrap runs from start word to group end, then group start up to start.
// - Hybrid burst wraps once, then moves to first word of the next group.
// - After hybrid wrap, addresses increment linearly until chip select goes high.
// - Config bit 2 picks wrap style: 0 hybrid, 1 legacy; resets to 1.
// - Addresses count 16-bit words; group spans half its byte length in words.
// - Length field: 00=128, 01=64, 10=16, 11=32 bytes; resets to 11.
// - Hybrid bit applies only when the burst type bit is 0.
`ifndef BAS_REGS_SVH
`define BAS_REGS_SVH

// ----------------------------------------------------------------
// Configuration register zero layout
// ----------------------------------------------------------------
`define BAS_CR0_RESET 16'h8f2f
`define BAS_HYB_BIT 2
`define BAS_LEN_MSB 1
`define BAS_LEN_LSB 0

// ----------------------------------------------------------------
// Command-address word layout
// ----------------------------------------------------------------
`define BAS_TYPE_BIT 45
`define BAS_UPPER_MSB 44
`define BAS_UPPER_LSB 16
`define BAS_LOWER_MSB 2

// ----------------------------------------------------------------
// Word masks per group length
// ----------------------------------------------------------------
`define BAS_MASK_128 32'h0000_003f
`define BAS_MASK_64 32'h0000_001f
`define BAS_MASK_32 32'h0000_000f
`define BAS_MASK_16 32'h0000_0007

`endif

// ### hw/bas_pkg.sv
// Types for the burst address sequencer
`default_nettype none
package bas_pkg;
	// Gray path idle -> wrap -> linear
	typedef enum logic [1:0] {
		BAS_IDLE = 2'b00,
		BAS_WRAP = 2'b01,
		BAS_LINEAR = 2'b11
	} bas_state_e;

	typedef enum logic [1:0] {
		BAS_LEN_128 = 2'b00,
		BAS_LEN_64 = 2'b01,
		BAS_LEN_16 = 2'b10,
		BAS_LEN_32 = 2'b11
	} bas_len_e;

	typedef logic [31:0] bas_addr_t;
endpackage
`default_nettype wire

// ### hw/bas_burst_seq.sv
// Burst word address sequencer with assertions
`include "bas_regs.svh"
`default_nettype none
module bas_burst_seq
	import bas_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Chip select pin, asynchronous
	input wire logic cs_b_i,
	// Configuration write, same clock
	input wire logic cfg_wr_i,
	input wire logic [15:0] cfg_data_i,
	// Command-address capture and word transfer, same clock
	input wire logic ca_valid_i,
	input wire logic [47:0] command_address_word_i,
	input wire logic word_adv_i,
	// Sequencer outputs
	output logic [31:0] word_addr_o,
	output logic burst_active_o,
	output logic wrapping_o,
	output logic [15:0] config_reg_zero_o
);

	// ----------------------------------------------------------------
	// Chip select synchroniser
	// ----------------------------------------------------------------
	logic cs_m1;
	logic cs_m2;
	logic cs_m3;
	logic cs_level;
	wire cs_agree = (cs_m2 == cs_m3);
	wire cs_rise = cs_agree & cs_m3 & ~cs_level;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cs_m1 <= 1'b1;
			cs_m2 <= 1'b1;
			cs_m3 <= 1'b1;
			cs_level <= 1'b1;
		end else begin
			cs_m1 <= cs_b_i;
			cs_m2 <= cs_m1;
			cs_m3 <= cs_m2;
			if (cs_agree) begin
				cs_level <= cs_m3;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration register zero
	// ----------------------------------------------------------------
	logic [15:0] config_reg_zero;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			config_reg_zero <= `BAS_CR0_RESET;
		end else if (cfg_wr_i) begin
			config_reg_zero <= cfg_data_i;
		end
	end

	wire hybrid_burst_select = config_reg_zero[`BAS_HYB_BIT];
	wire [1:0] len_field = config_reg_zero[`BAS_LEN_MSB:`BAS_LEN_LSB];

	// ----------------------------------------------------------------
	// Group mask decode
	// ----------------------------------------------------------------
	bas_addr_t cfg_mask;
	assign cfg_mask = (len_field == BAS_LEN_128) ? `BAS_MASK_128 :
		(len_field == BAS_LEN_64) ? `BAS_MASK_64 :
		(len_field == BAS_LEN_16) ? `BAS_MASK_16 : `BAS_MASK_32;

	// ----------------------------------------------------------------
	// Start decode
	// ----------------------------------------------------------------
	wire burst_type_bit = command_address_word_i[`BAS_TYPE_BIT];
	bas_addr_t ca_addr;
	assign ca_addr = {command_address_word_i[`BAS_UPPER_MSB:`BAS_UPPER_LSB],
		command_address_word_i[`BAS_LOWER_MSB:0]};
	wire start_wrap = ~burst_type_bit;
	wire start_hybrid = ~burst_type_bit & ~hybrid_burst_select;

	// ----------------------------------------------------------------
	// Burst state
	// ----------------------------------------------------------------
	bas_state_e state;
	bas_state_e next_state;
	bas_addr_t addr;
	bas_addr_t next_addr;
	bas_addr_t mask;
	bas_addr_t start_low;
	logic hybrid;

	wire idle_start = ca_valid_i & (state == BAS_IDLE);
	bas_addr_t wrap_step;
	bas_addr_t group_next;
	bas_addr_t lin_step;
	assign lin_step = addr + 32'h0000_0001;
	assign wrap_step = (addr & ~mask) | (lin_step & mask);
	assign group_next = (addr | mask) + 32'h0000_0001;
	wire wrap_done = ((wrap_step & mask) == start_low);

	always_comb begin
		next_state = state;
		next_addr = addr;
		if (idle_start) begin
			next_state = start_wrap ? BAS_WRAP : BAS_LINEAR;
			next_addr = ca_addr;
		end else if (cs_rise) begin
			next_state = BAS_IDLE;
		end else if (word_adv_i) begin
			case (state)
				BAS_WRAP: begin
					if (wrap_done && hybrid) begin
						next_state = BAS_LINEAR;
						next_addr = group_next;
					end else begin
						next_addr = wrap_step;
					end
				end
				BAS_LINEAR: begin
					next_addr = lin_step;
				end
				default: begin
					next_addr = addr;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			state <= BAS_IDLE;
			addr <= 32'h0000_0000;
			mask <= 32'h0000_0000;
			start_low <= 32'h0000_0000;
			hybrid <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			if (idle_start) begin
				mask <= cfg_mask;
				start_low <= ca_addr & cfg_mask;
				hybrid <= start_hybrid;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	assign word_addr_o = addr;
	assign config_reg_zero_o = config_reg_zero;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			burst_active_o <= 1'b0;
			wrapping_o <= 1'b0;
		end else begin
			burst_active_o <= (next_state != BAS_IDLE);
			wrapping_o <= (next_state == BAS_WRAP);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence wrap_last_s;
		state == BAS_WRAP && word_adv_i && !ca_valid_i && !cs_rise && wrap_done;
	endsequence

	cfg_reset_val_a: assert property (
		$rose(rst_b_i) |-> config_reg_zero[`BAS_HYB_BIT] == 1'b1 && len_field == 2'b11)
		else $error("config register zero left reset with wrong value");

	len_decode_a: assert property (
		idle_start |=> mask == (($past(len_field) == 2'b10) ? 32'h7 : ($past(len_field) == 2'b11) ? 32'hf :
			($past(len_field) == 2'b01) ? 32'h1f : 32'h3f))
		else $error("group mask does not match length field");

	upper_hold_a: assert property (
		state == BAS_WRAP && word_adv_i && !cs_rise && !ca_valid_i && !(wrap_done && hybrid)
		|=> (addr & ~mask) == ($past(addr) & ~mask))
		else $error("upper address bits moved during wrap");

	wrap_around_a: assert property (
		state == BAS_WRAP && word_adv_i && !cs_rise && !ca_valid_i && ((addr & mask) == mask) && !wrap_done
		|=> (addr & mask) == 32'h0)
		else $error("wrap did not return to group start");

	hybrid_next_a: assert property (
		wrap_last_s and hybrid |=> state == BAS_LINEAR && (addr & mask) == 32'h0 &&
		(addr & ~mask) == (($past(addr) & ~mask) + mask + 32'h1))
		else $error("hybrid did not move to next group");

	legacy_stay_a: assert property (
		wrap_last_s and !hybrid |=> state == BAS_WRAP && (addr & mask) == start_low)
		else $error("legacy wrap left the group");

	linear_inc_a: assert property (
		state == BAS_LINEAR && word_adv_i && !cs_rise && !ca_valid_i |=> addr == $past(addr) + 32'h1)
		else $error("linear address did not step by one");

	type_select_a: assert property (
		idle_start && burst_type_bit |=> state == BAS_LINEAR && !hybrid && addr == $past(ca_addr))
		else $error("linear burst type not honoured");

	cs_end_a: assert property (
		state != BAS_IDLE && cs_rise && !ca_valid_i |=> state == BAS_IDLE && !burst_active_o && !wrapping_o)
		else $error("burst not ended by chip select");

	sync_agree_a: assert property (
		cs_level != $past(cs_level) |-> $past(cs_m2) == $past(cs_m3))
		else $error("chip select level changed without agreement");

endmodule
`default_nettype wire

// ### dv/bas_host_model.sv
// Host controller model driving bursts and config writes
`default_nettype none
module bas_host_model (
	// Clock
	input wire logic clk_i,
	// Burst and config lines toward the device
	output logic cs_b_o,
	output logic ca_valid_o,
	output logic [47:0] ca_o,
	output logic word_adv_o,
	output logic cfg_wr_o,
	output logic [15:0] cfg_data_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cs_b_o = 1'b1;
		ca_valid_o = 1'b0;
		ca_o = 48'h0;
		word_adv_o = 1'b0;
		cfg_wr_o = 1'b0;
		cfg_data_o = 16'h0;
	end

	// ----------------------------------------------------------------
	// One clock of traffic; address lines scrambled when not valid
	// ----------------------------------------------------------------
	task automatic drive(input logic cs, cv, adv, input logic [47:0] w);
		@(posedge clk_i);
		cs_b_o <= cs;
		ca_valid_o <= cv;
		ca_o <= cv ? w : ~ca_o;
		word_adv_o <= adv;
		#1;
	endtask

	task automatic cfg(input logic [15:0] d);
		@(posedge clk_i);
		cfg_wr_o <= 1'b1;
		cfg_data_o <= d;
		@(posedge clk_i);
		cfg_wr_o <= 1'b0;
		cfg_data_o <= ~d;
		#1;
	endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the burst address sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	wire logic cs_b, ca_valid, adv, cfg_wr;
	wire logic [47:0] ca;
	wire logic [15:0] cfg_data;
	logic [31:0] word_addr_o;
	logic burst_active_o, wrapping_o;
	logic [15:0] config_reg_zero_o;
	int failures = 0;
	int n_compared = 0;
	logic [15:0] rnd = 16'h8754;

	always #25 sys_clk_i = ~sys_clk_i;

	bas_host_model u_host (.clk_i(sys_clk_i), .cs_b_o(cs_b), .ca_valid_o(ca_valid), .ca_o(ca),
		.word_adv_o(adv), .cfg_wr_o(cfg_wr), .cfg_data_o(cfg_data));
	bas_burst_seq u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .cfg_wr_i(cfg_wr),
		.cfg_data_i(cfg_data), .ca_valid_i(ca_valid), .command_address_word_i(ca), .word_adv_i(adv),
		.word_addr_o(word_addr_o), .burst_active_o(burst_active_o), .wrapping_o(wrapping_o),
		.config_reg_zero_o(config_reg_zero_o));

	// ----------------------------------------------------------------
	// Expectations
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [31:0] mask_of(input logic [1:0] len);
		case (len)
			2'b00: return 32'h0000_003f;
			2'b01: return 32'h0000_001f;
			2'b10: return 32'h0000_0007;
			default: return 32'h0000_000f;
		endcase
	endfunction

	function automatic logic [31:0] exp_addr(input logic [31:0] s, m, input int mode, i);
		logic [31:0] n;
		n = s + i;
		if (mode == 2) return n;
		if (mode == 1 || i <= m) return (s & ~m) | (n & m);
		return (s & ~m) + m + 1 + (i - m - 1);
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] s, m;
		logic [47:0] w;
		logic [15:0] d;
		int n, k;
		repeat (8) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk("cfg reset", {16'h0, config_reg_zero_o}, 32'h0000_8f2f);
		chk("addr reset", word_addr_o, 32'h0);
		for (int len = 0; len < 4; len++) begin
			for (int mode = 0; mode < 3; mode++) begin
				d = 16'h8f28 | (mode == 1 ? 16'h0004 : 16'h0000) | 16'(len);
				u_host.cfg(d);
				chk("cfg", {16'h0, config_reg_zero_o}, {16'h0, d});
				m = mask_of(2'(len));
				rnd = lfsr(rnd);
				w = {2'b00, mode == 2, 21'h0, rnd[15:8], 13'h0, rnd[2:0]};
				if (len == 2 && mode == 0) w[23:0] = 24'h01_0004;
				s = {w[44:16], w[2:0]};
				n = 2 * (m + 1) + 3;
				repeat (5) u_host.drive(1'b0, 1'b0, 1'b0, w);
				u_host.drive(1'b0, 1'b1, 1'b0, w);
				for (int i = 0; i <= n; i++) begin
					rnd = lfsr(rnd);
					u_host.drive(1'b0, i == 3, i < n, {rnd, rnd, rnd});
					chk("addr", word_addr_o, exp_addr(s, m, mode, i));
					chk("wrap", {31'h0, wrapping_o}, {31'h0, mode == 1 || (mode == 0 && i <= m)});
					chk("active", {31'h0, burst_active_o}, 32'h1);
				end
				k = 0;
				while (burst_active_o !== 1'b0 && k < 10) begin
					u_host.drive(1'b1, 1'b0, 1'b0, w);
					k++;
				end
				if (k == 10) begin
					failures++;
					$display("[ERR] burst end expected 0 seen 1");
					end_of_test();
				end
				repeat (2) u_host.drive(1'b1, 1'b0, 1'b1, w);
				chk("addr hold", word_addr_o, exp_addr(s, m, mode, n));
				chk("wrap end", {31'h0, wrapping_o}, 32'h0);
				$display("burst len %0d mode %0d done", len, mode);
			end
		end
		end_of_test();
	end
endmodule
`default_nettype wire
